// ### logic/bus_matrix_config.sv
// bus matrix configuration block with an axi4-lite register port
`timescale 1ns/1ps
module bus_matrix_config (
    input  wire logic       sys_clk,          // 40 mhz system clock
    input  wire logic       rst,              // synchronous, active high
    input  wire logic [7:0] s_axi_awaddr,     // write address
    input  wire logic       s_axi_awvalid,    // write address valid
    output logic            s_axi_awready,    // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0] s_axi_wstrb,      // byte enables
    input  wire logic       s_axi_wvalid,     // write data valid
    output logic            s_axi_wready,     // write data ready
    output logic [1:0]      s_axi_bresp,      // write response
    output logic            s_axi_bvalid,     // write response valid
    input  wire logic       s_axi_bready,     // write response ready
    input  wire logic [7:0] s_axi_araddr,     // read address
    input  wire logic       s_axi_arvalid,    // read address valid
    output logic            s_axi_arready,    // read address ready
    output logic [31:0]     s_axi_rdata,      // read data
    output logic [1:0]      s_axi_rresp,      // read response
    output logic            s_axi_rvalid,     // read data valid
    input  wire logic       s_axi_rready,     // read data ready
    input  wire logic [4:0] unmapped_req,     // one-cycle unmapped access per initiator
    input  wire logic       debug_mode,       // cpu in debug mode
    output logic [4:0]      bus_error,        // error pulse back to initiator
    output logic [4:0]      access_done,      // completion pulse per initiator
    input  wire logic       cpu_dram_req,     // cpu data ram access pulse
    output logic            cpu_dram_ack,     // access completes
    output logic [2:0]      arb_mode,         // arbitration mode to the matrix
    output logic            irq               // level interrupt
);
    // ==========================================
    // register state
    logic [4:0]  err_en_reg;
    logic        ws_reg;
    logic [4:0]  status_reg;
    logic [4:0]  irq_en_reg;
    logic [4:0]  status_next;
    logic [4:0]  clear_mask;
    logic [31:0] cfg_word;

    // ==========================================
    // write channel bookkeeping
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have;
    logic        w_have;
    logic        do_write;
    logic        aw_got_next;
    logic        w_got_next;
    logic        bvalid_next;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        rvalid_next;
    logic        ws_pend_reg;

    // accept address and data in either order, answer once both are in
    always_comb begin
        aw_have     = aw_got_reg | (s_axi_awvalid & s_axi_awready);
        w_have      = w_got_reg | (s_axi_wvalid & s_axi_wready);
        do_write    = aw_have & w_have & ~s_axi_bvalid;
        aw_got_next = aw_have & ~do_write;
        w_got_next  = w_have & ~do_write;
        bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
        waddr       = aw_got_reg ? awaddr_q : s_axi_awaddr;
        wdata       = w_got_reg ? wdata_q : s_axi_wdata;
        wstrb       = w_got_reg ? wstrb_q : s_axi_wstrb;
        rvalid_next = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);
    end

    // write handshake; ready drops while a beat is parked, so payload is never lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= bus_matrix_pkg::RESP_OKAY;
        end else begin
            aw_got_reg    <= aw_got_next;
            w_got_reg     <= w_got_next;
            s_axi_awready <= ~aw_got_next & ~bvalid_next;
            s_axi_wready  <= ~w_got_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                if (waddr == bus_matrix_pkg::CFG_OFF || waddr == bus_matrix_pkg::CLEAR_OFF
                    || waddr == bus_matrix_pkg::ENABLE_OFF) begin
                    s_axi_bresp <= bus_matrix_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= bus_matrix_pkg::RESP_SLVERR;
                end
            end
        end
    end

    // ==========================================
    // configuration register
    // only the implemented fields are stored, so other bits cannot take a write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            err_en_reg <= bus_matrix_pkg::ERR_EN_RST;
            ws_reg     <= bus_matrix_pkg::WS_RST;
            arb_mode   <= bus_matrix_pkg::ARB_RST;
        end else if (do_write && waddr == bus_matrix_pkg::CFG_OFF) begin
            if (wstrb[bus_matrix_pkg::ERR_LANE]) begin
                err_en_reg <= wdata[bus_matrix_pkg::ERR_POS +: 5];
            end
            if (wstrb[bus_matrix_pkg::LOW_LANE]) begin
                ws_reg   <= wdata[bus_matrix_pkg::WS_POS];
                arb_mode <= wdata[bus_matrix_pkg::ARB_POS +: 3];
            end
        end
    end

    assign cfg_word = (32'(err_en_reg) << bus_matrix_pkg::ERR_POS)
                    | (32'(ws_reg) << bus_matrix_pkg::WS_POS)
                    | (32'(arb_mode) << bus_matrix_pkg::ARB_POS);

    // ==========================================
    // interrupt status, clear and enable
    // a clear in the cycle of a new error leaves the bit set
    always_comb begin
        clear_mask = 5'h00;
        if (do_write && waddr == bus_matrix_pkg::CLEAR_OFF && wstrb[0]) begin
            clear_mask = wdata[4:0];
        end
        status_next = (status_reg & ~clear_mask) | bus_error;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_reg <= 5'h00;
            irq_en_reg <= bus_matrix_pkg::IRQ_EN_RST;
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (do_write && waddr == bus_matrix_pkg::ENABLE_OFF && wstrb[0]) begin
                irq_en_reg <= wdata[4:0];
            end
            irq <= |(status_next & irq_en_reg);
        end
    end

    // ==========================================
    // read channel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= bus_matrix_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rresp <= bus_matrix_pkg::RESP_OKAY;
                if (s_axi_araddr == bus_matrix_pkg::CFG_OFF) begin
                    s_axi_rdata <= cfg_word;
                end else if (s_axi_araddr == bus_matrix_pkg::STATUS_OFF) begin
                    s_axi_rdata <= {27'h0, status_reg};
                end else if (s_axi_araddr == bus_matrix_pkg::CLEAR_OFF) begin
                    s_axi_rdata <= 32'h0;
                end else if (s_axi_araddr == bus_matrix_pkg::ENABLE_OFF) begin
                    s_axi_rdata <= {27'h0, irq_en_reg};
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= bus_matrix_pkg::RESP_SLVERR;
                end
            end
        end
    end

    // ==========================================
    // per-initiator error return
    // cpu checking is masked in debug mode so a debugger probe never traps the core
    genvar gi;
    for (gi = 0; gi < bus_matrix_pkg::NUM_INIT; gi++) begin : g_init
        logic gate;
        assign gate = err_en_reg[gi] & ~(debug_mode &&
                      (gi == bus_matrix_pkg::IDX_CPU_INSTR || gi == bus_matrix_pkg::IDX_CPU_DATA));
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                bus_error[gi]   <= 1'b0;
                access_done[gi] <= 1'b0;
            end else begin
                bus_error[gi]   <= unmapped_req[gi] & gate;
                access_done[gi] <= unmapped_req[gi];
            end
        end
    end

    // ==========================================
    // data ram address setup wait state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ws_pend_reg  <= 1'b0;
            cpu_dram_ack <= 1'b0;
        end else begin
            ws_pend_reg  <= cpu_dram_req & ws_reg;
            cpu_dram_ack <= (cpu_dram_req & ~ws_reg) | ws_pend_reg;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_shared;
        unmapped_req[4] && err_en_reg[4] |=> bus_error[4] ##1 status_reg[4];
    endproperty
    a_shared: assert property (p_shared) else $error("shared bus error lost");

    property p_debug;
        unmapped_req[3] |=> bus_error[3] == $past(err_en_reg[3]);
    endproperty
    a_debug: assert property (p_debug) else $error("debug unit error wrong");

    property p_dma;
        unmapped_req[2] && !err_en_reg[2] |=> !bus_error[2];
    endproperty
    a_dma: assert property (p_dma) else $error("dma error not suppressed");

    property p_dma_on;
        unmapped_req[2] && err_en_reg[2] |=> bus_error[2];
    endproperty
    a_dma_on: assert property (p_dma_on) else $error("dma error lost");

    property p_cpu_data;
        unmapped_req[1] |=> bus_error[1] == ($past(err_en_reg[1]) && !$past(debug_mode));
    endproperty
    a_cpu_data: assert property (p_cpu_data) else $error("cpu data error wrong");

    property p_cpu_instr;
        unmapped_req[0] && err_en_reg[0] && !debug_mode |=> bus_error[0];
    endproperty
    a_cpu_instr: assert property (p_cpu_instr) else $error("cpu fetch error lost");

    property p_ws;
        cpu_dram_req && ws_reg |=> !cpu_dram_ack ##1 cpu_dram_ack;
    endproperty
    a_ws: assert property (p_ws) else $error("wait state timing wrong");

    property p_ws_off;
        cpu_dram_req && !ws_reg |=> cpu_dram_ack;
    endproperty
    a_ws_off: assert property (p_ws_off) else $error("zero wait state timing wrong");

    property p_arb;
        do_write && waddr == bus_matrix_pkg::CFG_OFF && wstrb[0]
        |=> arb_mode == $past(wdata[2:0]);
    endproperty
    a_arb: assert property (p_arb) else $error("mode field not stored");

    property p_arb_rst;
        @(posedge sys_clk) disable iff (1'b0) rst |=> arb_mode == bus_matrix_pkg::ARB_MODE1;
    endproperty
    a_arb_rst: assert property (p_arb_rst) else $error("mode not 1 after reset");

    property p_zero;
        s_axi_rvalid && $past(s_axi_araddr == bus_matrix_pkg::CFG_OFF && s_axi_arvalid)
        |-> (s_axi_rdata & 32'hffe0_ffb8) == 32'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("reserved bits not zero");

    property p_done;
        unmapped_req[4] |=> access_done[4];
    endproperty
    a_done: assert property (p_done) else $error("unmapped access hung");
endmodule

// ### logic/bus_matrix_pkg.sv
// shared constants of the bus matrix configuration block
package bus_matrix_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] CFG_OFF     = 8'h00;
    localparam logic [7:0] STATUS_OFF  = 8'h04;
    localparam logic [7:0] CLEAR_OFF   = 8'h08;
    localparam logic [7:0] ENABLE_OFF  = 8'h0c;
    // ==========================================
    // field layout of the configuration register
    localparam int ERR_POS  = 16;  // five error enables, 20:16
    localparam int WS_POS   = 6;   // data ram wait state
    localparam int ARB_POS  = 0;   // arbitration mode, 2:0
    localparam int ERR_LANE = 2;   // byte lane holding 20:16
    localparam int LOW_LANE = 0;   // byte lane holding 6 and 2:0
    localparam int NUM_INIT = 5;
    // initiator index within the error enables
    localparam int IDX_CPU_INSTR = 0;
    localparam int IDX_CPU_DATA  = 1;
    localparam int IDX_DMA       = 2;
    localparam int IDX_DEBUG     = 3;
    localparam int IDX_SHARED    = 4;
    // ==========================================
    // reset values
    localparam logic [4:0] ERR_EN_RST = 5'h1f;
    localparam logic       WS_RST     = 1'b1;
    localparam logic [2:0] ARB_RST    = 3'h1;
    localparam logic [4:0] IRQ_EN_RST = 5'h00;
    // arbitration codes
    localparam logic [2:0] ARB_MODE0  = 3'h0;
    localparam logic [2:0] ARB_MODE1  = 3'h1;
    localparam logic [2:0] ARB_MODE2  = 3'h2;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verification/initiator_model.sv
// model of the bus initiators: cpu fetch, cpu data, dma, debug unit, shared bus
`timescale 1ns/1ps
module initiator_model (
    input  wire logic       sys_clk,      // system clock
    output logic [4:0]      unmapped_req, // unmapped access strobes
    output logic            debug_mode,   // cpu debug level
    output logic            cpu_dram_req, // data ram access strobe
    input  wire logic [4:0] bus_error,    // error back per initiator
    input  wire logic [4:0] access_done,  // completion per initiator
    input  wire logic       cpu_dram_ack  // data ram completion
);
    // ==========================================
    // idle at time zero
    initial begin
        unmapped_req = 5'h00;
        debug_mode = 1'b0;
        cpu_dram_req = 1'b0;
    end
    // debug level changes right after an edge
    task automatic set_debug(input logic v);
        @(posedge sys_clk);
        debug_mode <= v;
    endtask
    // one-cycle strobe, answer taken in the next cycle
    task automatic fire(input logic [4:0] m, output logic [4:0] err, output logic [4:0] dn);
        @(posedge sys_clk);
        unmapped_req <= m;
        @(posedge sys_clk);
        unmapped_req <= 5'h00;
        @(posedge sys_clk);
        err = bus_error;
        dn = access_done;
    endtask
    // data ram access; bounded wait so a lost ack cannot hang us
    task automatic dram(output int lat);
        @(posedge sys_clk);
        cpu_dram_req <= 1'b1;
        @(posedge sys_clk);
        cpu_dram_req <= 1'b0;
        lat = 0;
        do begin
            @(posedge sys_clk);
            lat++;
        end while (cpu_dram_ack !== 1'b1 && lat < 8);
    endtask
endmodule

// ### verification/testbench.sv
// self-checking bench of the bus matrix configuration block
`timescale 1ns/1ps
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, dram_req, dram_ack, dbg, irq;
    logic [1:0]  bresp, rresp;
    logic [4:0]  ureq, berr, adone;
    logic [2:0]  arb_mode;
    int          mismatches = 0, check_count = 0, cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    bus_matrix_config DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .unmapped_req(ureq), .debug_mode(dbg), .bus_error(berr),
        .access_done(adone), .cpu_dram_req(dram_req), .cpu_dram_ack(dram_ack),
        .arb_mode(arb_mode), .irq(irq));
    initiator_model initiator (.sys_clk(sys_clk), .unmapped_req(ureq), .debug_mode(dbg),
        .cpu_dram_req(dram_req), .bus_error(berr), .access_done(adone),
        .cpu_dram_ack(dram_ack));

    // ==========================================
    // reporting
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, well above the length of the sequence
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ==========================================
    // axi4-lite master: each channel released at its own handshake edge
    // no cycle limit in the tasks: only the hang guard ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'h3;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
            end
        end while (bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ==========================================
    // test sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [4:0]  e, dn;
        int          lat;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(bus_matrix_pkg::CFG_OFF, d, r);
        chk("cfg reset", 32'h001f0041, d);
        chk("cfg rd resp", 32'(bus_matrix_pkg::RESP_OKAY), 32'(r));
        chk("arb reset", 32'h1, 32'(arb_mode));
        initiator.dram(lat);
        chk("ws on latency", 2, lat);
        // one initiator at a time, every enable set
        for (int i = 0; i < 5; i++) begin
            initiator.fire(5'h01 << i, e, dn);
            chk("error one", 32'h01 << i, 32'(e));
            chk("done one", 32'h01 << i, 32'(dn));
        end
        wr(bus_matrix_pkg::ENABLE_OFF, 32'h1f, r);
        chk("enable wr resp", 32'(bus_matrix_pkg::RESP_OKAY), 32'(r));
        rd(bus_matrix_pkg::STATUS_OFF, d, r);
        chk("status", 32'h1f, d);
        chk("irq on", 32'h1, 32'(irq));
        wr(bus_matrix_pkg::CLEAR_OFF, 32'h1f, r);
        rd(bus_matrix_pkg::STATUS_OFF, d, r);
        chk("status clr", 32'h0, d);
        chk("irq off", 32'h0, 32'(irq));
        wr(bus_matrix_pkg::ENABLE_OFF, 32'h0, r);
        // reserved bits ignored, enables and wait state cleared
        wr(bus_matrix_pkg::CFG_OFF, 32'hffe0ffba, r);
        rd(bus_matrix_pkg::CFG_OFF, d, r);
        chk("cfg masked", 32'h2, d);
        initiator.fire(5'h1f, e, dn);
        chk("irq masked", 32'h0, 32'(irq));
        chk("error off", 32'h00, 32'(e));
        chk("done off", 32'h1f, 32'(dn));
        initiator.dram(lat);
        chk("ws off latency", 1, lat);
        // only the defined codes are written
        for (int c = 0; c < 3; c++) begin
            wr(bus_matrix_pkg::CFG_OFF, c, r);
            chk("arb code", c, 32'(arb_mode));
        end
        wr(bus_matrix_pkg::CFG_OFF, 32'h001f0041, r);
        initiator.set_debug(1'b1);
        initiator.fire(5'h1f, e, dn);
        chk("error debug", 32'h1c, 32'(e));
        initiator.set_debug(1'b0);
        rd(8'h10, d, r);
        chk("bad rd resp", 32'(bus_matrix_pkg::RESP_SLVERR), 32'(r));
        chk("bad rd data", 32'h0, d);
        wr(8'h10, 32'hffffffff, r);
        chk("bad wr resp", 32'(bus_matrix_pkg::RESP_SLVERR), 32'(r));
        give_verdict();
    end
endmodule
